// ===== design/rsscfg_bank.sv
// regulator sequence slot configuration bank with enable outputs and register port
`timescale 1ns/1ns
module rsscfg_bank #(
	parameter int REG_COUNT    = rsscfg_pkg::REG_COUNT,
	parameter int LINEAR_COUNT = rsscfg_pkg::LINEAR_COUNT
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic [7:0]           regAddr,
	input  wire logic [7:0]           regWrData,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	output logic      [7:0]           regRdData,
	input  wire logic [2:0]           seq0Slot,
	input  wire logic [2:0]           seq1Slot,
	input  wire logic [1:0]           seqSlotTick,
	input  wire logic [1:0]           seqPowerUp,
	input  wire logic [REG_COUNT-1:0] modeEnable,
	output logic      [REG_COUNT-1:0] regEnable,
	output logic      [REG_COUNT-1:0] regExcluded
);

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	logic [7:0]           cfg_reg [REG_COUNT];
	logic [7:0]           regRdData_reg;
	logic [7:0]           regRdData_next;
	logic [REG_COUNT-1:0] regEnable_reg;
	logic [REG_COUNT-1:0] regEnable_next;
	logic [REG_COUNT-1:0] regExcluded_reg;
	logic [REG_COUNT-1:0] excludedNow;
	logic [2:0]           accessIndex;
	logic                 accessHit;

	always_comb begin
		accessIndex = rsscfg_pkg::rsscfg_index(regAddr);
		accessHit   = accessIndex[2];
	end

	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : gCfg
			// writes outside the bank fall away silently
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					cfg_reg[gi] <= rsscfg_pkg::CFG_RESET;
				end else if (regWrite && accessHit && (accessIndex[1:0] == 2'(gi))) begin
					cfg_reg[gi] <= regWrData;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// read port
	// ****************************************************************
	always_comb begin
		regRdData_next = rsscfg_pkg::READ_IDLE;
		if (regRead) begin
			if (accessHit) begin
				regRdData_next = cfg_reg[accessIndex[1:0]];
			end else if (regAddr == rsscfg_pkg::ENABLE_STATUS_OFFSET) begin
				regRdData_next = 8'({regExcluded_reg, regEnable_reg});
			end
		end
	end

	// data only in the cycle after the strobe, idle zero otherwise
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData_reg <= rsscfg_pkg::READ_IDLE;
		end else begin
			regRdData_reg <= regRdData_next;
		end
	end

	// ****************************************************************
	// slot matching and enables
	// ****************************************************************
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : gMatch
			rsscfg_slot_match uMatch (
				.cfg         (cfg_reg[gi]),
				.seq0Slot    (seq0Slot),
				.seq1Slot    (seq1Slot),
				.seqSlotTick (seqSlotTick),
				.seqPowerUp  (seqPowerUp),
				.modeEnable  (modeEnable[gi]),
				.enableNow   (regEnable_reg[gi]),
				.excluded    (excludedNow[gi]),
				.enableNext  (regEnable_next[gi])
			);
		end
	endgenerate

	// all regulators start off until a sequence or the mode control says otherwise
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regEnable_reg <= '0;
		end else begin
			regEnable_reg <= regEnable_next;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regExcluded_reg <= '1;
		end else begin
			regExcluded_reg <= excludedNow;
		end
	end

	assign regRdData   = regRdData_reg;
	assign regEnable   = regEnable_reg;
	assign regExcluded = regExcluded_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence sWriteCfg0;
		regWrite && (regAddr == rsscfg_pkg::LDO6_SEQUENCE_CFG_OFFSET);
	endsequence

	sequence sReadCfg0;
		regRead && !regWrite && (regAddr == rsscfg_pkg::LDO6_SEQUENCE_CFG_OFFSET);
	endsequence

	AST_UP_FIELD_STORED: assert property (@(posedge clk) disable iff (!reset_n)
		sWriteCfg0 |=> cfg_reg[0][5:3] == $past(regWrData[5:3]))
		else $error("power-up slot not stored from bits 5:3");

	// one idle cycle between the write and the read, as software usually leaves
	AST_DOWN_FIELD_READBACK: assert property (@(posedge clk) disable iff (!reset_n)
		sWriteCfg0 ##2 sReadCfg0 |=> regRdData[2:0] == $past(regWrData[2:0], 3))
		else $error("power-down slot not read back from bits 2:0");

	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : gChk
			AST_SEQ0_OWNER_UP: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] == 2'b00) && seqSlotTick[0] && seqPowerUp[0]
				&& (seq0Slot == cfg_reg[gi][5:3]) |=> regEnable[gi])
				else $error("sequencer 0 power-up slot did not enable its regulator");

			AST_SEQ1_BOTH_CODES: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] inside {2'b01, 2'b10}) && seqSlotTick[1] && seqPowerUp[1]
				&& (seq1Slot == cfg_reg[gi][5:3]) |=> regEnable[gi])
				else $error("sequencer 1 power-up slot did not enable its regulator");

			AST_EXCLUDED_IGNORES_SEQ: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] == 2'b11) && !modeEnable[gi] && (|seqSlotTick) |=> !regEnable[gi]
				##0 regExcluded[gi])
				else $error("excluded regulator followed a sequencer");

			AST_DOWN_SLOT_DISABLES: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] == 2'b00) && seqSlotTick[0] && !seqPowerUp[0]
				&& (seq0Slot == cfg_reg[gi][2:0]) |=> !regEnable[gi])
				else $error("power-down slot did not disable the regulator");

			AST_HOLD_OFF_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] != 2'b11) && !(|seqSlotTick) |=> $stable(regEnable[gi]))
				else $error("sequenced regulator changed without a slot tick");
		end
		for (gi = 0; gi < LINEAR_COUNT; gi++) begin : gLinChk
			AST_LINEAR_MODE_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] == 2'b11) |=> regEnable[gi] == $past(modeEnable[gi]))
				else $error("excluded linear regulator not following its power-mode enable");
		end
	endgenerate

	// ****************************************************************
	// read port checks
	// ****************************************************************
	sequence sReadStatus;
		regRead && (regAddr == rsscfg_pkg::ENABLE_STATUS_OFFSET);
	endsequence

	sequence sReadBank;
		regRead && accessHit;
	endsequence

	sequence sReadUnmapped;
		regRead && !accessHit && (regAddr != rsscfg_pkg::ENABLE_STATUS_OFFSET);
	endsequence

	// stale read data would look like a second answer to software
	AST_READ_IDLE_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
		!regRead |=> regRdData == rsscfg_pkg::READ_IDLE)
		else $error("read data not idle outside a read");

	AST_BANK_READBACK: assert property (@(posedge clk) disable iff (!reset_n)
		sReadBank |=> regRdData == $past(cfg_reg[accessIndex[1:0]]))
		else $error("bank read did not return the stored byte");

	AST_UNMAPPED_READ_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
		sReadUnmapped |=> regRdData == rsscfg_pkg::READ_IDLE)
		else $error("unmapped read returned data");

	AST_STATUS_READ: assert property (@(posedge clk) disable iff (!reset_n)
		sReadStatus |=> regRdData == 8'($past({regExcluded, regEnable})))
		else $error("status read did not show exclusion and enable flags");

	// ****************************************************************
	// per-regulator register and ownership checks
	// ****************************************************************
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : gBankChk
			sequence sWriteOwn;
				regWrite && (regAddr == rsscfg_pkg::LDO6_SEQUENCE_CFG_OFFSET + 8'(gi));
			endsequence

			sequence sWriteStatus;
				regWrite && (regAddr == rsscfg_pkg::ENABLE_STATUS_OFFSET);
			endsequence

			sequence sOwnSeq0;
				cfg_reg[gi][7:6] == 2'b00;
			endsequence

			sequence sOwnSeq1;
				cfg_reg[gi][7:6] inside {2'b01, 2'b10};
			endsequence

			AST_CFG_WRITE_LANDS: assert property (@(posedge clk) disable iff (!reset_n)
				sWriteOwn |=> cfg_reg[gi] == $past(regWrData))
				else $error("write to a sequencing register did not land");

			// status is read-only; a write there must not alias into the bank
			AST_STATUS_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
				sWriteStatus |=> $stable(cfg_reg[gi]))
				else $error("status write changed a sequencing register");

			AST_EXCLUDED_FLAG_SET: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] == 2'b11) |=> regExcluded[gi])
				else $error("excluded source not flagged");

			AST_OWNED_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] != 2'b11) |=> !regExcluded[gi])
				else $error("sequenced regulator flagged as excluded");

			AST_SEQ1_DOWN_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
				sOwnSeq1 ##0 (seqSlotTick[1] && !seqPowerUp[1] && (seq1Slot == cfg_reg[gi][2:0]))
				|=> !regEnable[gi])
				else $error("sequencer 1 power-down slot did not disable its regulator");

			AST_SEQ0_IGNORES_SEQ1: assert property (@(posedge clk) disable iff (!reset_n)
				sOwnSeq0 ##0 !seqSlotTick[0] |=> $stable(regEnable[gi]))
				else $error("regulator of sequencer 0 followed sequencer 1");

			AST_SEQ1_IGNORES_SEQ0: assert property (@(posedge clk) disable iff (!reset_n)
				sOwnSeq1 ##0 !seqSlotTick[1] |=> $stable(regEnable[gi]))
				else $error("regulator of sequencer 1 followed sequencer 0");

			// a tick at any other slot must leave the enable alone
			AST_SEQ0_WRONG_UP_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
				sOwnSeq0 ##0 (seqSlotTick[0] && seqPowerUp[0] && (seq0Slot != cfg_reg[gi][5:3]))
				|=> $stable(regEnable[gi]))
				else $error("power-up tick at a foreign slot changed the enable");

			AST_SEQ1_WRONG_UP_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
				sOwnSeq1 ##0 (seqSlotTick[1] && seqPowerUp[1] && (seq1Slot != cfg_reg[gi][5:3]))
				|=> $stable(regEnable[gi]))
				else $error("power-up tick at a foreign slot changed the enable");

			AST_SEQ0_WRONG_DOWN_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
				sOwnSeq0 ##0 (seqSlotTick[0] && !seqPowerUp[0] && (seq0Slot != cfg_reg[gi][2:0]))
				|=> $stable(regEnable[gi]))
				else $error("power-down tick at a foreign slot changed the enable");

			AST_SEQ1_WRONG_DOWN_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
				sOwnSeq1 ##0 (seqSlotTick[1] && !seqPowerUp[1] && (seq1Slot != cfg_reg[gi][2:0]))
				|=> $stable(regEnable[gi]))
				else $error("power-down tick at a foreign slot changed the enable");
		end
		// buck follows its mode enable too when excluded, so it is never stranded off
		for (gi = LINEAR_COUNT; gi < REG_COUNT; gi++) begin : gBuckChk
			AST_BUCK_MODE_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg_reg[gi][7:6] == 2'b11) |=> regEnable[gi] == $past(modeEnable[gi]))
				else $error("excluded buck regulator not following its mode enable");
		end
	endgenerate

endmodule // rsscfg_bank

// ===== design/rsscfg_pkg.sv
// constants, field layout and decode helpers for the regulator sequence slot bank
// ****************************************************************
// Overview of operation
// - source code 00 hands the regulator to sequencer 0, codes 01 and 10 both hand it to sequencer 1.
// - source code 11 keeps the regulator out of every sequence, so no sequencer turns it on or off.
// - an excluded linear regulator takes its enable from its power-mode control instead.
// - bits 5:3 of each register hold the power-up slot, values 0 to 7 meaning slots 0 to 7.
// - bits 2:0 of each register hold the power-down slot, with the same direct slot numbering.
// ****************************************************************
package rsscfg_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int         REG_COUNT                 = 4;
	localparam int         LINEAR_COUNT              = 3;
	localparam logic [7:0] LDO6_SEQUENCE_CFG_OFFSET  = 8'ha1;
	localparam logic [7:0] LDO7_SEQUENCE_CFG_OFFSET  = 8'ha2;
	localparam logic [7:0] LDO8_SEQUENCE_CFG_OFFSET  = 8'ha3;
	localparam logic [7:0] BUCK0_SEQUENCE_CFG_OFFSET = 8'ha4;
	localparam logic [7:0] ENABLE_STATUS_OFFSET      = 8'hb0;
	// excluded from sequencing, both slots at 0
	localparam logic [7:0] CFG_RESET                 = 8'hc0;
	localparam logic [7:0] READ_IDLE                 = 8'h00;

	// ****************************************************************
	// field layout
	// ****************************************************************
	localparam int SRC_MSB  = 7;
	localparam int SRC_LSB  = 6;
	localparam int UP_MSB   = 5;
	localparam int UP_LSB   = 3;
	localparam int DOWN_MSB = 2;
	localparam int DOWN_LSB = 0;

	typedef enum logic [1:0] {
		SRC_SEQUENCER_0   = 2'b00,
		SRC_SEQUENCER_1   = 2'b01,
		SRC_SEQUENCER_1_B = 2'b10,
		SRC_EXCLUDED      = 2'b11
	} rsscfg_source_type;

	// one-hot owner {sequencer_1, sequencer_0}; zero when excluded
	function automatic logic [1:0] rsscfg_owner(input logic [7:0] cfg);
		logic [1:0] owner;
		owner = 2'b00;
		case (rsscfg_source_type'(cfg[SRC_MSB:SRC_LSB]))
			SRC_SEQUENCER_0:   owner = 2'b01;
			SRC_SEQUENCER_1:   owner = 2'b10;
			SRC_SEQUENCER_1_B: owner = 2'b10;
			default:           owner = 2'b00;
		endcase
		return owner;
	endfunction

	// address to bank index; valid flag low for anything outside the bank
	function automatic logic [2:0] rsscfg_index(input logic [7:0] addr);
		logic [2:0] result;
		result = 3'h0;
		case (addr)
			LDO6_SEQUENCE_CFG_OFFSET:  result = 3'h4;
			LDO7_SEQUENCE_CFG_OFFSET:  result = 3'h5;
			LDO8_SEQUENCE_CFG_OFFSET:  result = 3'h6;
			BUCK0_SEQUENCE_CFG_OFFSET: result = 3'h7;
			default:                   result = 3'h0;
		endcase
		return result;
	endfunction

endpackage

// ===== design/rsscfg_slot_match.sv
// per-regulator slot matcher: next enable level from its config byte and both sequencers
`timescale 1ns/1ns
module rsscfg_slot_match (
	input  wire logic [7:0] cfg,
	input  wire logic [2:0] seq0Slot,
	input  wire logic [2:0] seq1Slot,
	input  wire logic [1:0] seqSlotTick,
	input  wire logic [1:0] seqPowerUp,
	input  wire logic       modeEnable,
	input  wire logic       enableNow,
	output logic            excluded,
	output logic            enableNext
);
	logic [1:0] owner;
	logic [2:0] slotNow;
	logic       tick;
	logic       up;

	always_comb begin
		owner   = rsscfg_pkg::rsscfg_owner(cfg);
		slotNow = owner[1] ? seq1Slot : seq0Slot;
		tick    = |(owner & seqSlotTick);
		up      = |(owner & seqPowerUp);
		excluded   = (owner == 2'b00);
		enableNext = enableNow;
		if (excluded) begin
			// no sequencer reaches an excluded regulator
			enableNext = modeEnable;
		end else if (tick && up && (slotNow == cfg[rsscfg_pkg::UP_MSB:rsscfg_pkg::UP_LSB])) begin
			enableNext = 1'b1;
		end else if (tick && !up && (slotNow == cfg[rsscfg_pkg::DOWN_MSB:rsscfg_pkg::DOWN_LSB])) begin
			enableNext = 1'b0;
		end
	end
endmodule // rsscfg_slot_match

// ===== dv/rsscfg_bank_tb_top.sv
// self-checking bench for the regulator sequence slot bank
`timescale 1ns/1ns
module rsscfg_bank_tb_top;
	logic       clk, reset_n, regWrite, regRead;
	logic [7:0] regAddr, regWrData, regRdData, cfg;
	logic [2:0] seq0Slot, seq1Slot, up, dn;
	logic [1:0] seqSlotTick, seqPowerUp, own;
	logic [3:0] modeEnable, regEnable, regExcluded, expEn, expEx;
	int         err_count;
	int         n_compared;

	rsscfg_bank i_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .seq0Slot(seq0Slot),
		.seq1Slot(seq1Slot), .seqSlotTick(seqSlotTick), .seqPowerUp(seqPowerUp),
		.modeEnable(modeEnable), .regEnable(regEnable), .regExcluded(regExcluded));

	// ****************************************************************
	// access tasks
	// ****************************************************************
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'h1;
		@(posedge clk);
		regWrite <= 1'h0;
	endtask

	// read data is sampled just after the edge that registers it
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge clk);
		regRead <= 1'h0;
		#1;
		check8(what, exp, regRdData);
	endtask

	task automatic tick(input logic [1:0] t, input logic [2:0] s, input logic [1:0] pu);
		@(posedge clk);
		seqSlotTick <= t;
		seq0Slot <= s;
		seq1Slot <= s;
		seqPowerUp <= pu;
		@(posedge clk);
		seqSlotTick <= 2'h0;
		#1;
	endtask

	task automatic chk_out(input string what);
		check8({what, " enable"}, {4'h0, expEn}, {4'h0, regEnable});
		check8({what, " excluded"}, {4'h0, expEx}, {4'h0, regExcluded});
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// clock, watchdog, tests
	// ****************************************************************
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// whole run is well under 1000 cycles; allow five times that
	initial begin
		#100000;
		err_count++;
		final_report();
	end

	initial begin
		reset_n = 1'h0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'h0;
		regRead = 1'h0;
		seq0Slot = 3'h0;
		seq1Slot = 3'h0;
		seqSlotTick = 2'h0;
		seqPowerUp = 2'h0;
		modeEnable = 4'h0;
		err_count = 0;
		n_compared = 0;
		repeat (20) @(posedge clk);
		reset_n <= 1'h1;
		expEn = 4'h0;
		expEx = 4'hf;
		for (int i = 0; i < 4; i++) begin
			rd(8'ha1 + 8'(i), 8'hc0, "cfg reset");
		end
		rd(8'hb0, 8'hf0, "status reset");
		chk_out("reset");
		$display("test reset done");
		// status is read-only, unmapped places ignore writes
		wr(8'hb0, 8'h00);
		wr(8'ha5, 8'h3f);
		rd(8'hb0, 8'hf0, "status read-only");
		rd(8'ha5, 8'h00, "unmapped");
		$display("test refused access done");
		for (int r = 0; r < 4; r++) begin
			for (int c = 0; c < 4; c++) begin
				up = 3'(7 - r);
				dn = 3'(r);
				cfg = {2'(c), up, dn};
				own = (c == 0) ? 2'h1 : ((c == 3) ? 2'h0 : 2'h2);
				wr(8'ha1 + 8'(r), cfg);
				rd(8'ha1 + 8'(r), cfg, "cfg readback");
				@(posedge clk);
				#1;
				check8("read idle", 8'h00, regRdData);
				expEx[r] = (c == 3);
				tick(~own, up, 2'h3);
				chk_out("foreign tick");
				tick(own, up ^ 3'h1, 2'h3);
				chk_out("wrong slot");
				tick(own, up, 2'h3);
				expEn[r] = (c != 3);
				chk_out("power-up slot");
				rd(8'hb0, {expEx, expEn}, "status");
				tick(own, dn, 2'h0);
				expEn[r] = 1'h0;
				chk_out("power-down slot");
				if (c == 3) begin
					@(posedge clk);
					modeEnable <= 4'(1 << r);
					@(posedge clk);
					#1;
					expEn[r] = 1'h1;
					chk_out("mode enable on");
					@(posedge clk);
					modeEnable <= 4'h0;
					@(posedge clk);
					#1;
					expEn[r] = 1'h0;
					chk_out("mode enable off");
				end
				$display("test regulator %0d source %0d done", r, c);
			end
		end
		final_report();
	end
endmodule // rsscfg_bank_tb_top
